// [hdl/phy_status_irq_regs.vh]
`ifndef PHY_STATUS_IRQ_REGS_VH
`define PHY_STATUS_IRQ_REGS_VH
// Register indices; byte address is four times the index
`define IDX_SUMMARY      8'h10
`define IDX_GENERAL_CONFIG      8'h11
`define IDX_EVENTS_1     8'h12
`define IDX_EVENTS_2     8'h13
`define IDX_RX_ERR       8'h15
`define IDX_SOFT_RESET   8'h00
// Field positions
`define BIT_SUMMARY_IRQ  7
`define BIT_LINK_UP      0
`define BIT_SOFT_RESET   15
`define BIT_IRQ_POL      3
`define BIT_IRQ_FORCE    2
`define BIT_IRQ_EN       1
`define BIT_PIN_IS_IRQ   0
`define LSB_TX_DEPTH     5
`define BIT_RHF_FLAG     15
`define BIT_LINK_FLAG    13
`define BIT_ESD_FLAG     11
`define BIT_RHF_EN       7
`define BIT_LINK_EN      5
`define BIT_ESD_EN       3
`define BIT_PAGE_FLAG    13
`define BIT_POL_FLAG     9
`define BIT_PAGE_EN      5
`define BIT_POL_EN       1
`define BIT_EV2_SPARE    0
// Reset values and error counter limits
`define RST_GENERAL_CONFIG      16'h002a
`define RST_ZERO         16'h0000
`define ERR_HALF         16'h8000
`define ERR_MAX          16'hffff
// Write masks and pin-side defaults
`define WMASK_CFG_LO     8'h6f
`define WMASK_CFG_HI     8'h0c
`define RST_DEPTH        4'h5
`endif

// [hdl/phy_status_irq.v]
// What this block does
// - Sticky summary flag sets when interrupt pin asserted; cleared by writing zero.
// - Link change latches event bit 13; current link state readable, one means up.
// - Two-bit transmit buffer depth selects 4,5,6,8 nibbles; resets to 01.
// - Polarity bit one gives active-low pin, zero active-high; resets one.
// - Force bit drives pin active regardless of event flags.
// - Pin signals interrupts only while master enable or force bit is one; resets one.
// - Pin-function bit one makes pin interrupt output, zero power-down input.
// - Error counter half full latches bit 15 until register read.
// - Half-full event interrupts only when bit 7 enable set.
// - Link-change event interrupts only when bit 5 enable set.
// - Electrostatic discharge event latches bit 11 until cleared.
// - Discharge event interrupts only when bit 3 enable set.
// - Autonegotiation page received latches second register bit 13.
// - Page event interrupts only when second register bit 5 set.
// - Receive polarity change latches second register bit 9.
// - Polarity event interrupts only when second register bit 1 set.
// - Receive errors counted in sixteen bits, saturating at maximum.
// - Reading the counter register clears it to zero, or to one if an error arrives in the read cycle.
// - Soft reset bit returns all registers and interrupt status to defaults.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "phy_status_irq_regs.vh"
`default_nettype none
module phy_status_irq (
  input  wire        clk,
  input  wire        arst_n,
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        link_up,
  input  wire        rx_err,
  input  wire        esd_event,
  input  wire        page_rcvd,
  input  wire        rx_pol_change,
  input  wire        irq_or_sleep_pin_in,
  output reg         irq_or_sleep_pin_out,
  output reg         irq_or_sleep_pin_oe_n,
  output reg         sleep_request,
  output reg  [3:0]  tx_depth_nibbles
);

  // Reset release through two flops
  reg rst_s1_reg;
  reg rst_n;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // Outside inputs pass two flops before use
  reg [5:0] in_s1_reg;
  reg [5:0] in_s2_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Pin bit idles high; a zero here would fake a power-down request
      in_s1_reg <= 6'h20;
      in_s2_reg <= 6'h20;
    end else begin
      in_s1_reg <= {irq_or_sleep_pin_in, rx_pol_change, page_rcvd, esd_event, rx_err, link_up};
      in_s2_reg <= in_s1_reg;
    end
  end
  wire link_s   = in_s2_reg[0];
  wire rxerr_s  = in_s2_reg[1];
  wire esd_s    = in_s2_reg[2];
  wire page_s   = in_s2_reg[3];
  wire pol_s    = in_s2_reg[4];
  wire pin_in_s = in_s2_reg[5];

  // Edge history; event inputs are levels, one event per rising edge, link change on either edge
  reg link_d_reg;
  reg rxerr_d_reg;
  reg esd_d_reg;
  reg page_d_reg;
  reg pol_d_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_d_reg  <= 1'b0;
      rxerr_d_reg <= 1'b0;
      esd_d_reg   <= 1'b0;
      page_d_reg  <= 1'b0;
      pol_d_reg   <= 1'b0;
    end else begin
      link_d_reg  <= link_s;
      rxerr_d_reg <= rxerr_s;
      esd_d_reg   <= esd_s;
      page_d_reg  <= page_s;
      pol_d_reg   <= pol_s;
    end
  end
  wire link_chg  = link_s ^ link_d_reg;
  wire rxerr_ev  = rxerr_s & ~rxerr_d_reg;
  wire esd_ev    = esd_s & ~esd_d_reg;
  wire page_ev   = page_s & ~page_d_reg;
  wire pol_ev    = pol_s & ~pol_d_reg;

  // Bus decode: word addresses; writes in one cycle, reads one wait state
  wire [7:0] idx   = avs_address[9:2];
  wire       wr_lo = avs_write & avs_byteenable[0];
  wire       wr_hi = avs_write & avs_byteenable[1];

  // Read wait state so registered data stands when waitrequest drops
  reg rd_wait_done_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_wait_done_reg <= 1'b0;
    end else begin
      rd_wait_done_reg <= avs_read & ~rd_wait_done_reg;
    end
  end
  // Side effects of a read happen once, at its first edge
  wire rd_first = avs_read & ~rd_wait_done_reg;
  assign avs_waitrequest = rd_first;

  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  wire rd_ev1 = rd_first & hit(idx, `IDX_EVENTS_1);
  wire rd_ev2 = rd_first & hit(idx, `IDX_EVENTS_2);
  wire rd_err = rd_first & hit(idx, `IDX_RX_ERR);
  wire soft_rst = wr_hi & hit(idx, `IDX_SOFT_RESET) & avs_writedata[`BIT_SOFT_RESET];

  // Configuration register
  reg [15:0] general_config_reg;
  reg [2:0]  en1_reg; // rhf, link, esd enables
  reg [1:0]  en2_reg; // page, pol enables
  reg        ev2_spare_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      general_config_reg   <= `RST_GENERAL_CONFIG;
      en1_reg       <= 3'h0;
      en2_reg       <= 2'h0;
      ev2_spare_reg <= 1'b0;
    end else if (soft_rst) begin
      general_config_reg   <= `RST_GENERAL_CONFIG;
      en1_reg       <= 3'h0;
      en2_reg       <= 2'h0;
      ev2_spare_reg <= 1'b0;
    end else begin
      // Only writable fields kept; reserved bits stay zero
      if (wr_lo && hit(idx, `IDX_GENERAL_CONFIG)) begin
        general_config_reg[7:0] <= avs_writedata[7:0] & `WMASK_CFG_LO;
      end
      if (wr_hi && hit(idx, `IDX_GENERAL_CONFIG)) begin
        general_config_reg[15:8] <= avs_writedata[15:8] & `WMASK_CFG_HI;
      end
      // Enables keep their value across read clears of the flags
      if (wr_lo && hit(idx, `IDX_EVENTS_1)) begin
        en1_reg <= {avs_writedata[`BIT_RHF_EN], avs_writedata[`BIT_LINK_EN],
                    avs_writedata[`BIT_ESD_EN]};
      end
      if (wr_lo && hit(idx, `IDX_EVENTS_2)) begin
        en2_reg       <= {avs_writedata[`BIT_PAGE_EN], avs_writedata[`BIT_POL_EN]};
        ev2_spare_reg <= avs_writedata[`BIT_EV2_SPARE];
      end
    end
  end
  wire       irq_pol    = general_config_reg[`BIT_IRQ_POL];
  wire       irq_force  = general_config_reg[`BIT_IRQ_FORCE];
  wire       irq_en     = general_config_reg[`BIT_IRQ_EN];
  wire       pin_is_irq = general_config_reg[`BIT_PIN_IS_IRQ];
  wire [1:0] depth_sel  = general_config_reg[`LSB_TX_DEPTH+1:`LSB_TX_DEPTH];

  reg [15:0] err_cnt_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_cnt_reg <= `RST_ZERO;
    end else if (soft_rst) begin
      err_cnt_reg <= `RST_ZERO;
    end else if (rd_err) begin
      // clear on read; an error in the read cycle counts as one
      err_cnt_reg <= {15'h0000, rxerr_ev};
      // Holds at the top so a long burst never wraps to a small count
    end else if (rxerr_ev && err_cnt_reg != `ERR_MAX) begin
      err_cnt_reg <= err_cnt_reg + 16'h0001;
    end
  end
  // Top bit set means half full; saturation keeps it set
  wire half_full = (err_cnt_reg >= `ERR_HALF);

  // Latch with clear; a set in the clearing cycle wins
  function latch_next;
    input set;
    input flag;
    input clr;
    begin
      latch_next = set | (flag & ~clr);
    end
  endfunction

  // Latched event flags; a set in the clearing cycle wins
  reg rhf_reg;
  reg link_f_reg;
  reg esd_f_reg;
  reg page_f_reg;
  reg pol_f_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rhf_reg    <= 1'b0;
      link_f_reg <= 1'b0;
      esd_f_reg  <= 1'b0;
      page_f_reg <= 1'b0;
      pol_f_reg  <= 1'b0;
    end else if (soft_rst) begin
      rhf_reg    <= 1'b0;
      link_f_reg <= 1'b0;
      esd_f_reg  <= 1'b0;
      page_f_reg <= 1'b0;
      pol_f_reg  <= 1'b0;
    end else begin
      // half-full latch, cleared by read; re-sets while still half full
      rhf_reg    <= latch_next(half_full, rhf_reg, rd_ev1);
      link_f_reg <= latch_next(link_chg, link_f_reg, rd_ev1);
      esd_f_reg  <= latch_next(esd_ev, esd_f_reg, rd_ev1);
      page_f_reg <= latch_next(page_ev, page_f_reg, rd_ev2);
      pol_f_reg  <= latch_next(pol_ev, pol_f_reg, rd_ev2);
    end
  end

  wire rhf_gated  = rhf_reg & en1_reg[2];
  wire link_gated = link_f_reg & en1_reg[1];
  wire esd_gated  = esd_f_reg & en1_reg[0];
  wire page_gated = page_f_reg & en2_reg[1];
  wire pol_gated  = pol_f_reg & en2_reg[0];
  wire any_ev = rhf_gated | link_gated | esd_gated | page_gated | pol_gated;
  wire irq_active = irq_force | (irq_en & any_ev);

  // summary sticky flag, write zero clears, set wins
  reg summary_reg;
  wire clr_summary = wr_lo & hit(idx, `IDX_SUMMARY) & ~avs_writedata[`BIT_SUMMARY_IRQ];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      summary_reg <= 1'b0;
    end else if (soft_rst) begin
      summary_reg <= 1'b0;
    end else begin
      summary_reg <= latch_next(irq_active & pin_is_irq, summary_reg, clr_summary);
    end
  end

  // Depth code to nibble count
  function [3:0] depth_of;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   depth_of = 4'h4;
        2'b01:   depth_of = 4'h5;
        2'b10:   depth_of = 4'h6;
        default: depth_of = 4'h8;
      endcase
    end
  endfunction

  // Pin drive, depth decode and power-down request from flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_or_sleep_pin_out  <= 1'b1;
      irq_or_sleep_pin_oe_n <= 1'b1;
      sleep_request         <= 1'b0;
      tx_depth_nibbles      <= `RST_DEPTH;
    end else begin
      irq_or_sleep_pin_out  <= irq_active ^ irq_pol;
      irq_or_sleep_pin_oe_n <= ~pin_is_irq;
      // Pin read as active-low power-down request when used as input
      sleep_request         <= ~pin_is_irq & ~pin_in_s;
      tx_depth_nibbles      <= depth_of(depth_sel);
    end
  end

  // Read mux, registered at the first edge of a read
  reg [15:0] rd_word;
  always @* begin
    // Reserved bits read zero
    rd_word = 16'h0000;
    if (hit(idx, `IDX_SUMMARY)) begin
      rd_word[`BIT_SUMMARY_IRQ] = summary_reg;
      rd_word[`BIT_LINK_UP]     = link_s;
    end else if (hit(idx, `IDX_GENERAL_CONFIG)) begin
      rd_word = general_config_reg;
    end else if (hit(idx, `IDX_EVENTS_1)) begin
      rd_word[`BIT_RHF_FLAG]  = rhf_reg;
      rd_word[`BIT_LINK_FLAG] = link_f_reg;
      rd_word[`BIT_ESD_FLAG]  = esd_f_reg;
      rd_word[`BIT_RHF_EN]    = en1_reg[2];
      rd_word[`BIT_LINK_EN]   = en1_reg[1];
      rd_word[`BIT_ESD_EN]    = en1_reg[0];
    end else if (hit(idx, `IDX_EVENTS_2)) begin
      rd_word[`BIT_PAGE_FLAG] = page_f_reg;
      rd_word[`BIT_POL_FLAG]  = pol_f_reg;
      rd_word[`BIT_PAGE_EN]   = en2_reg[1];
      rd_word[`BIT_POL_EN]    = en2_reg[0];
      rd_word[`BIT_EV2_SPARE] = ev2_spare_reg;
    end else if (hit(idx, `IDX_RX_ERR)) begin
      rd_word = err_cnt_reg;
    end
  end

  // Unmapped addresses read zero and ignore writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_first) begin
      avs_readdata <= {16'h0000, rd_word};
    end
  end

endmodule
`default_nettype wire

// [tb/phy_status_irq_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module phy_status_irq_chk (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        irq_or_sleep_pin_out,
  input wire logic        irq_or_sleep_pin_oe_n,
  input wire logic [3:0]  tx_depth_nibbles
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Decoded requests, word index
  wire [7:0]  ix = avs_address[9:2];
  wire [15:0] wd = avs_writedata[15:0];
  wire        cw = avs_write && ix == 8'h11 && avs_byteenable[0];
  wire        sr = avs_write && ix == 8'h00 && wd[15] && avs_byteenable[1];
  property p_sum; avs_read && ix == 8'h10 |=> (avs_readdata & 32'hffffff7e) == 0; endproperty
  a_sum: assert property (p_sum) else $error("summary spare bits set");
  property p_cfg; avs_read && ix == 8'h11 |=> (avs_readdata & 32'hfffff390) == 0; endproperty
  a_cfg: assert property (p_cfg) else $error("config spare bits set");
  property p_ev1; avs_read && ix == 8'h12 |=> (avs_readdata & 32'hffff5757) == 0; endproperty
  a_ev1: assert property (p_ev1) else $error("event1 spare bits set");
  property p_ev2; avs_read && ix == 8'h13 |=> (avs_readdata & 32'hffffdddc) == 0; endproperty
  a_ev2: assert property (p_ev2) else $error("event2 spare bits set");
  // Pin settles two edges after the write
  property p_frc; cw && wd[2] && wd[0] |-> ##2
    irq_or_sleep_pin_out == !$past(avs_writedata[3], 2) && !irq_or_sleep_pin_oe_n; endproperty
  a_frc: assert property (p_frc) else $error("forced pin not active");
  property p_msk; cw && !wd[2] && !wd[1] |-> ##2
    irq_or_sleep_pin_out == $past(avs_writedata[3], 2); endproperty
  a_msk: assert property (p_msk) else $error("pin active while disabled");
  property p_oe; cw |-> ##2 irq_or_sleep_pin_oe_n == !$past(avs_writedata[0], 2); endproperty
  a_oe: assert property (p_oe) else $error("pin direction wrong");
  property p_dep; tx_depth_nibbles inside {4'h4, 4'h5, 4'h6, 4'h8}; endproperty
  a_dep: assert property (p_dep) else $error("bad buffer depth");
  property p_srs; sr |-> ##2 tx_depth_nibbles == 4'h5 && irq_or_sleep_pin_oe_n; endproperty
  a_srs: assert property (p_srs) else $error("soft reset missed");
  c_frc: cover property (cw && wd[2]);
  c_srs: cover property (sr);
  c_cnt: cover property (avs_read && ix == 8'h15);
endmodule
bind phy_status_irq phy_status_irq_chk u_phy_status_irq_chk (.clk, .arst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .irq_or_sleep_pin_out, .irq_or_sleep_pin_oe_n, .tx_depth_nibbles);
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, pin_in = 1;
  logic [9:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0;
  logic [3:0]  avs_byteenable = 4'h3;
  logic [4:0]  ev = 0; // link, rx error, esd, page, polarity
  wire [31:0]  avs_readdata;
  wire [3:0]   tx_depth_nibbles;
  wire         avs_waitrequest, irq_or_sleep_pin_out, irq_or_sleep_pin_oe_n, sleep_request;
  int          mismatches = 0, cmp_count = 0;
  logic [9:0]  ra[6] = '{10'h040, 10'h044, 10'h048, 10'h04c, 10'h054, 10'h058};
  logic [15:0] rv[6] = '{16'h0, 16'h002a, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] dv[4] = '{16'h4, 16'h5, 16'h6, 16'h8};
  logic [9:0]  er[3] = '{10'h048, 10'h04c, 10'h04c};
  logic [15:0] fb[3] = '{16'h0800, 16'h2000, 16'h0200};
  logic [15:0] eb[3] = '{16'h0008, 16'h0020, 16'h0002};
  always #2 clk = ~clk;
  phy_status_irq u_phy_status_irq (.clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .link_up(ev[0]),
    .rx_err(ev[1]), .esd_event(ev[2]), .page_rcvd(ev[3]), .rx_pol_change(ev[4]),
    .irq_or_sleep_pin_in(pin_in), .irq_or_sleep_pin_out, .irq_or_sleep_pin_oe_n,
    .sleep_request, .tx_depth_nibbles);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Held until waitrequest is seen low; two idle edges let pin flops settle
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    cyc(2);
  endtask
  // Read data taken at the edge that sees waitrequest low
  task automatic rdc(input string nm, input logic [9:0] a, input logic [15:0] e);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    chk(nm, avs_readdata[15:0], e);
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    cyc(2);
    ev[i] <= 1'b0;
    cyc(6);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    cyc(8);
    arst_n <= 1'b1;
    cyc(4);
    for (int i = 0; i < 6; i++) rdc("reset", ra[i], rv[i]);
    chk("depth", {12'h0, tx_depth_nibbles}, 16'h5);
    wr(10'h058, 16'hffff);
    rdc("unmapped", 10'h058, 16'h0);
    for (int i = 0; i < 4; i++) begin
      wr(10'h044, 16'h000a | 16'(i << 5));
      chk("depth", {12'h0, tx_depth_nibbles}, dv[i]);
    end
    // Link change with enable, then flags cleared by read
    wr(10'h044, 16'h000b);
    wr(10'h048, 16'h0020);
    ev[0] <= 1'b1;
    cyc(8);
    chk("pin", {15'h0, irq_or_sleep_pin_out}, 16'h0);
    rdc("summary", 10'h040, 16'h0081);
    rdc("ev1", 10'h048, 16'h2020);
    rdc("ev1", 10'h048, 16'h0020);
    chk("pin", {15'h0, irq_or_sleep_pin_out}, 16'h1);
    wr(10'h040, 16'h0);
    rdc("summary", 10'h040, 16'h0001);
    // Master enable off hides the pin but not the flag
    wr(10'h044, 16'h0009);
    ev[0] <= 1'b0;
    cyc(8);
    chk("pin", {15'h0, irq_or_sleep_pin_out}, 16'h1);
    rdc("ev1", 10'h048, 16'h2020);
    rdc("summary", 10'h040, 16'h0);
    wr(10'h044, 16'h000b);
    wr(10'h048, 16'h0);
    for (int i = 0; i < 3; i++) begin
      pulse(i + 2);
      chk("pin", {15'h0, irq_or_sleep_pin_out}, 16'h1);
      rdc("flag", er[i], fb[i]);
      wr(er[i], eb[i]);
      pulse(i + 2);
      chk("pin", {15'h0, irq_or_sleep_pin_out}, 16'h0);
      rdc("flag", er[i], fb[i] | eb[i]);
      wr(er[i], 16'h0);
    end
    wr(10'h044, 16'h0005);
    chk("pin", {15'h0, irq_or_sleep_pin_out}, 16'h1);
    wr(10'h044, 16'h000d);
    chk("pin", {15'h0, irq_or_sleep_pin_out}, 16'h0);
    // Counter clears on read; half full raises its flag
    wr(10'h044, 16'h000b);
    wr(10'h048, 16'h0080);
    repeat (3) pulse(1);
    rdc("count", 10'h054, 16'h3);
    rdc("count", 10'h054, 16'h0);
    repeat (32768) begin
      ev[1] <= 1'b1;
      @(posedge clk);
      ev[1] <= 1'b0;
      @(posedge clk);
    end
    cyc(8);
    chk("pin", {15'h0, irq_or_sleep_pin_out}, 16'h0);
    rdc("count", 10'h054, 16'h8000);
    rdc("ev1", 10'h048, 16'h8080);
    rdc("ev1", 10'h048, 16'h0080);
    // Pin as power-down input
    wr(10'h044, 16'h002a);
    pin_in <= 1'b0;
    cyc(6);
    chk("sleep", {15'h0, sleep_request}, 16'h1);
    chk("oe_n", {15'h0, irq_or_sleep_pin_oe_n}, 16'h1);
    pin_in <= 1'b1;
    wr(10'h044, 16'h0065);
    wr(10'h000, 16'h8000);
    cyc(2);
    rdc("cfg", 10'h044, 16'h002a);
    chk("depth", {12'h0, tx_depth_nibbles}, 16'h5);
    end_of_test;
  end
  // Hang guard, well beyond the expected run
  initial begin
    cyc(90000);
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire
